// file: rtl/bstap_pkg.sv
package bstap_pkg;

    // ------------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------------
    localparam int          IR_LEN         = 10;
    localparam logic [9:0]  IR_CAPTURE     = 10'h001;
    localparam logic [9:0]  OP_SAMPLE      = 10'h005;
    localparam logic [9:0]  OP_EXTEST      = 10'h000;
    localparam logic [9:0]  OP_BYPASS      = 10'h3ff;
    localparam logic [9:0]  OP_IDCODE      = 10'h006;
    localparam logic [9:0]  OP_USERCODE    = 10'h007;
    localparam logic [9:0]  OP_CLAMP       = 10'h00a;
    localparam logic [9:0]  OP_HIGHZ       = 10'h00b;
    localparam logic [9:0]  OP_CONFIG      = 10'h002;

    // ------------------------------------------------------------------
    // Data registers and cells
    // ------------------------------------------------------------------
    localparam int          ID_LEN         = 32;
    localparam int          CELL_BITS      = 3;
    localparam int          CELL_IN        = 0;
    localparam int          CELL_OE        = 1;
    localparam int          CELL_OUT       = 2;
    localparam int          RESET_TMS_HIGH = 5;

    // ------------------------------------------------------------------
    // Port controller states
    // ------------------------------------------------------------------
    typedef enum logic [15:0] {
        ST_RESET     = 16'h0001,
        ST_IDLE      = 16'h0002,
        ST_SEL_DR    = 16'h0004,
        ST_CAP_DR    = 16'h0008,
        ST_SHIFT_DR  = 16'h0010,
        ST_EXIT1_DR  = 16'h0020,
        ST_PAUSE_DR  = 16'h0040,
        ST_EXIT2_DR  = 16'h0080,
        ST_UPD_DR    = 16'h0100,
        ST_SEL_IR    = 16'h0200,
        ST_CAP_IR    = 16'h0400,
        ST_SHIFT_IR  = 16'h0800,
        ST_EXIT1_IR  = 16'h1000,
        ST_PAUSE_IR  = 16'h2000,
        ST_EXIT2_IR  = 16'h4000,
        ST_UPD_IR    = 16'h8000
    } bstap_state_t;

    typedef enum logic [2:0] {
        SEL_BYPASS = 3'h1,
        SEL_BSR    = 3'h2,
        SEL_ID     = 3'h4
    } bstap_sel_t;

endpackage : bstap_pkg

// file: rtl/bstap_chain_if.sv
`timescale 1ns/1ps
`default_nettype none
// Shift controls from the port controller to the boundary-scan chain.
interface bstap_chain_if #(parameter int NPINS = 4);
    logic             capture;
    logic             shift;
    logic             update;
    logic             sdi;
    logic             sdo;
    logic             drive;
    logic             highz;
    modport ctrl  (output capture, output shift, output update, output sdi,
                   output drive, output highz, input sdo);
    modport chain (input capture, input shift, input update, input sdi,
                   input drive, input highz, output sdo);
endinterface : bstap_chain_if
`default_nettype wire

// file: rtl/bstap_chain.sv
`timescale 1ns/1ps
`default_nettype none
module bstap_chain
    import bstap_pkg::*;
#(
    parameter int NPINS = 4
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Controls
    bstap_chain_if.chain          bus,
    // Core and pin side
    input  wire logic [NPINS-1:0] core_out_i,
    input  wire logic [NPINS-1:0] core_oe_i,
    input  wire logic [NPINS-1:0] pin_in_i,
    output logic      [NPINS-1:0] pin_out_o,
    output logic      [NPINS-1:0] pin_oe_o
);
    localparam int LEN = NPINS * CELL_BITS;

    logic [LEN-1:0] shreg;
    logic [LEN-1:0] upd;
    logic [LEN-1:0] cap;

    // ------------------------------------------------------------------
    // Three-bit cells, one per pin, chained into one shift path
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_cell
            assign cap[g*CELL_BITS+CELL_IN]  = pin_in_i[g];
            assign cap[g*CELL_BITS+CELL_OE]  = core_oe_i[g];
            assign cap[g*CELL_BITS+CELL_OUT] = core_out_i[g];
            always_comb begin
                if (bus.highz) begin // see RULE_09
                    pin_out_o[g] = 1'b0;
                    pin_oe_o[g]  = 1'b0;
                end else if (bus.drive) begin
                    pin_out_o[g] = upd[g*CELL_BITS+CELL_OUT];
                    pin_oe_o[g]  = upd[g*CELL_BITS+CELL_OE];
                end else begin
                    pin_out_o[g] = core_out_i[g];
                    pin_oe_o[g]  = core_oe_i[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shreg <= '0;
        end else if (bus.capture) begin
            shreg <= cap;
        end else if (bus.shift) begin
            shreg <= {bus.sdi, shreg[LEN-1:1]}; // see RULE_08
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            upd <= '0;
        end else if (bus.update) begin
            upd <= shreg;
        end
    end

    assign bus.sdo = shreg[0];
endmodule : bstap_chain
`default_nettype wire

// file: rtl/bstap_top.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01 - Serial input sampled into the selected path on rising test clock.
// RULE_02 - Serial output changes to the next bit on falling test clock.
// RULE_03 - Serial output undriven whenever nothing is being shifted out.
// RULE_04 - Mode select evaluated and state changes made on rising edge only.
// RULE_05 - Tester changes serial input on falling edges.
// RULE_06 - Tester keeps mode select high when scan is unused.
// RULE_07 - One-bit bypass register is the shortest serial path.
// RULE_08 - Boundary chain is three-bit cells per pin, input to output.
// RULE_09 - User pins float while configuration through the port runs.
// RULE_10 - Loaded instruction picks the operation and the data register.
// RULE_11 - No test reset pin; reset comes only from mode select sequencing.
// RULE_12 - Serial input feeds instruction and data paths; output follows shifted one.
// RULE_13 - Five cycles of mode select high reach test-logic-reset from anywhere.
// RULE_14 - Test-logic-reset disables scan and loads the identification instruction.
// RULE_15 - Instruction register is ten bits long.
// RULE_16 - Output enabled on first falling edge in shift, off on first after.
// RULE_17 - Unimplemented instruction codes select the bypass register.
module bstap_top
    import bstap_pkg::*;
#(
    parameter int          NPINS   = 4,
    parameter logic [31:0] IDCODE  = 32'h1234_5001, // Arbitrary value.
    parameter logic [31:0] USERID  = 32'hffff_ffff
) (
    // Core clock and reset
    input  wire logic             CORE_CLK_I,
    input  wire logic             RST_I,
    // Test port pins
    input  wire logic             TCK_I,
    input  wire logic             TMS_I,
    input  wire logic             TDI_I,
    output logic                  TDO_O,
    output logic                  TDO_OE_O,
    // Configuration status
    input  wire logic             CONFIG_BUSY_I,
    // Core and pin side
    input  wire logic [NPINS-1:0] CORE_OUT_I,
    input  wire logic [NPINS-1:0] CORE_OE_I,
    input  wire logic [NPINS-1:0] PIN_IN_I,
    output logic      [NPINS-1:0] PIN_OUT_O,
    output logic      [NPINS-1:0] PIN_OE_O,
    output logic                  SCAN_MODE_O
);
    bstap_chain_if #(.NPINS(NPINS)) cif ();

    logic [2:0]        tck_s;
    logic [1:0]        tms_s;
    logic [1:0]        tdi_s;
    logic [1:0]        cfg_s;
    logic              rise;
    logic              fall;
    bstap_state_t      state;
    bstap_state_t      next_state;
    logic [IR_LEN-1:0] ir_sh;
    logic [IR_LEN-1:0] ir;
    logic              bypass;
    logic [ID_LEN-1:0] id_sh;
    bstap_sel_t        sel;
    logic              ext_drive;
    logic              ext_highz;
    logic              tdo_bit;
    logic [NPINS-1:0]  pin_out;
    logic [NPINS-1:0]  pin_oe;
    logic [NPINS-1:0]  pin_s0;
    logic [NPINS-1:0]  pin_s1;
    logic              scan_float;

    // ------------------------------------------------------------------
    // Pin synchronisers and test clock edges
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tck_s <= '0;
            tms_s <= '1;
            tdi_s <= '1;
            cfg_s <= '0;
            pin_s0 <= '0;
            pin_s1 <= '0;
        end else begin
            tck_s <= {tck_s[1:0], TCK_I};
            tms_s <= {tms_s[0], TMS_I};
            tdi_s <= {tdi_s[0], TDI_I};
            cfg_s <= {cfg_s[0], CONFIG_BUSY_I};
            pin_s0 <= PIN_IN_I;
            pin_s1 <= pin_s0;
        end
    end

    // The test clock must be well under a quarter of the core rate.
    assign rise = tck_s[1] & ~tck_s[2];
    assign fall = ~tck_s[1] & tck_s[2];

    // ------------------------------------------------------------------
    // Port controller
    // ------------------------------------------------------------------
    always_comb begin
        case (state)
            ST_RESET:    next_state = tms_s[1] ? ST_RESET    : ST_IDLE; // see RULE_13
            ST_IDLE:     next_state = tms_s[1] ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   next_state = tms_s[1] ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   next_state = tms_s[1] ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms_s[1] ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms_s[1] ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms_s[1] ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms_s[1] ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   next_state = tms_s[1] ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   next_state = tms_s[1] ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   next_state = tms_s[1] ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms_s[1] ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms_s[1] ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms_s[1] ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms_s[1] ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   next_state = tms_s[1] ? ST_SEL_DR   : ST_IDLE;
            default:     next_state = ST_RESET;
        endcase
    end

    // RST_I stands for power-up; there is no test reset pin.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin // see RULE_11
        if (RST_I) begin
            state <= ST_RESET;
        end else if (rise) begin
            state <= next_state; // see RULE_04
        end
    end

    // ------------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ir_sh <= IR_CAPTURE;
        end else if (rise && state == ST_CAP_IR) begin
            ir_sh <= IR_CAPTURE;
        end else if (rise && state == ST_SHIFT_IR) begin
            ir_sh <= {tdi_s[1], ir_sh[IR_LEN-1:1]}; // see RULE_15
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ir <= OP_IDCODE;
        end else if (state == ST_RESET) begin
            ir <= OP_IDCODE; // see RULE_14
        end else if (rise && state == ST_UPD_IR) begin
            ir <= ir_sh;
        end
    end

    always_comb begin
        case (ir) // see RULE_10
            OP_SAMPLE, OP_EXTEST, OP_CLAMP: sel = SEL_BSR;
            OP_IDCODE, OP_USERCODE:         sel = SEL_ID;
            default:                        sel = SEL_BYPASS; // see RULE_17
        endcase
    end

    // Scan circuitry stays off in test-logic-reset.
    assign ext_drive = (state != ST_RESET) && (ir == OP_EXTEST || ir == OP_CLAMP);
    assign scan_float = (state != ST_RESET) && (ir == OP_HIGHZ);
    assign ext_highz = cfg_s[1] || scan_float; // see RULE_09

    // ------------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            bypass <= 1'b0;
        end else if (rise && state == ST_CAP_DR) begin
            bypass <= 1'b0;
        end else if (rise && state == ST_SHIFT_DR && sel == SEL_BYPASS) begin
            bypass <= tdi_s[1]; // see RULE_07
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            id_sh <= '0;
        end else if (rise && state == ST_CAP_DR) begin
            id_sh <= (ir == OP_USERCODE) ? USERID : IDCODE;
        end else if (rise && state == ST_SHIFT_DR && sel == SEL_ID) begin
            id_sh <= {tdi_s[1], id_sh[ID_LEN-1:1]}; // see RULE_01
        end
    end

    assign cif.capture = rise && state == ST_CAP_DR && sel == SEL_BSR;
    assign cif.shift   = rise && state == ST_SHIFT_DR && sel == SEL_BSR;
    assign cif.update  = rise && state == ST_UPD_DR && sel == SEL_BSR;
    assign cif.sdi     = tdi_s[1]; // see RULE_12
    assign cif.drive   = ext_drive;
    assign cif.highz   = ext_highz;

    bstap_chain #(.NPINS(NPINS)) u_chain (
        .clk_i      (CORE_CLK_I),
        .rst_i      (RST_I),
        .bus        (cif),
        .core_out_i (CORE_OUT_I),
        .core_oe_i  (CORE_OE_I),
        .pin_in_i   (pin_s1),
        .pin_out_o  (pin_out),
        .pin_oe_o   (pin_oe)
    );

    // ------------------------------------------------------------------
    // Serial output, driven from falling test clock edges
    // ------------------------------------------------------------------
    always_comb begin
        if (state == ST_SHIFT_IR) begin
            tdo_bit = ir_sh[0]; // see RULE_12
        end else begin
            case (sel)
                SEL_BSR: tdo_bit = cif.sdo;
                SEL_ID:  tdo_bit = id_sh[0];
                default: tdo_bit = bypass;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            TDO_O    <= 1'b0;
            TDO_OE_O <= 1'b0;
        end else if (fall) begin
            TDO_O    <= tdo_bit; // see RULE_02
            TDO_OE_O <= (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR); // see RULE_03 RULE_16
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PIN_OUT_O   <= '0;
            PIN_OE_O    <= '0;
            SCAN_MODE_O <= 1'b0;
        end else begin
            PIN_OUT_O   <= pin_out;
            PIN_OE_O    <= pin_oe;
            // High whenever scan logic rather than the core owns the pins.
            SCAN_MODE_O <= ext_drive || scan_float;
        end
    end
endmodule : bstap_top
`default_nettype wire

// file: dv/bstap_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bstap_top_assertions #(
    parameter int NPINS = 4
) (
    // Clock and reset
    input wire logic             CORE_CLK_I,
    input wire logic             RST_I,
    // Test port
    input wire logic             TCK_I,
    input wire logic             TMS_I,
    input wire logic             TDI_I,
    input wire logic             TDO_O,
    input wire logic             TDO_OE_O,
    // Pins and status
    input wire logic             CONFIG_BUSY_I,
    input wire logic [NPINS-1:0] CORE_OUT_I,
    input wire logic [NPINS-1:0] CORE_OE_I,
    input wire logic [NPINS-1:0] PIN_IN_I,
    input wire logic [NPINS-1:0] PIN_OUT_O,
    input wire logic [NPINS-1:0] PIN_OE_O,
    input wire logic             SCAN_MODE_O
);
    // ------------------------------------------------------------
    // Test clock edges seen from the raw pin
    // ------------------------------------------------------------
    logic       tck_q;
    logic       tms_at_rise;
    logic [3:0] since_fall;
    logic [2:0] tms_run;
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tck_q       <= 1'b0;
            tms_at_rise <= 1'b1;
            since_fall  <= 4'hf;
            tms_run     <= 3'h0;
        end else begin
            tck_q <= TCK_I;
            if (TCK_I && !tck_q) begin
                tms_at_rise <= TMS_I;
                tms_run     <= !TMS_I ? 3'h0 : (tms_run == 3'h7) ? tms_run : tms_run + 3'h1;
            end
            if (tck_q && !TCK_I) begin
                since_fall <= 4'h0;
            end else if (since_fall != 4'hf) begin
                since_fall <= since_fall + 4'h1;
            end
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    a_tdo_on_fall: assert property ($changed(TDO_O) |-> since_fall <= 4'h6)
        else $error("serial output moved away from a test clock fall");
    a_oe_on_fall: assert property ($changed(TDO_OE_O) |-> since_fall <= 4'h6)
        else $error("output enable moved away from a test clock fall");
    a_oe_rise_tms: assert property ($rose(TDO_OE_O) |-> !tms_at_rise)
        else $error("output enabled without a shift entry");
    a_oe_fall_tms: assert property ($fell(TDO_OE_O) |-> tms_at_rise)
        else $error("output disabled without leaving shift");
    a_tlr_tdo_off: assert property (tms_run >= 3'h5 |-> !TDO_OE_O)
        else $error("serial output driven in reset state");
    a_tlr_scan_off: assert property (tms_run >= 3'h5 |-> ##[0:12] !SCAN_MODE_O)
        else $error("scan mode kept after five mode-select highs");
    a_config_float: assert property (CONFIG_BUSY_I [*4] |=> PIN_OE_O == '0)
        else $error("pins driven during configuration");
    // Four quiet cycles give the synchroniser and the pin register time to settle.
    a_normal_pins: assert property ((!SCAN_MODE_O && !CONFIG_BUSY_I) [*4] |->
        {PIN_OUT_O, PIN_OE_O} == $past({CORE_OUT_I, CORE_OE_I}))
        else $error("pins do not follow the core");
    a_reset_quiet: assert property (@(posedge CORE_CLK_I) disable iff (1'b0)
        RST_I |=> !TDO_OE_O && !SCAN_MODE_O && PIN_OE_O == '0)
        else $error("outputs active under reset");
    c_shift: cover property ($rose(TDO_OE_O));
    c_scan: cover property ($rose(SCAN_MODE_O));
    c_float: cover property (CONFIG_BUSY_I [*4] ##1 PIN_OE_O == '0);
endmodule : bstap_top_assertions
`default_nettype wire

// file: dv/bstap_tester.sv
`timescale 1ns/1ps
`default_nettype none
module bstap_tester (
    // Time base
    input  wire logic core_clk_i,
    // Test port
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i
);
    // Idle levels match the pin pulls; the clock stands still between frames.
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    // One test clock period of eight core cycles; enter at a core falling edge.
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tck_o = 1'b0;
        tms_o = tms;
        tdi_o = tdi;
        repeat (4) @(negedge core_clk_i);
        tck_o = 1'b1;
        repeat (4) @(negedge core_clk_i);
        tdo = tdo_i;
    endtask
    // There is no reset pin, so five mode-select highs do it, then idle.
    task automatic tms_reset();
        logic b;
        repeat (5) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask
endmodule : bstap_tester
`default_nettype wire

// file: dv/bstap_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bstap_top_tb;
    import bstap_pkg::*;
    localparam int          NP  = 4;
    localparam logic [31:0] ID  = 32'h1234_5001; // Arbitrary value.
    localparam logic [31:0] UID = 32'h5a5a_0c3c; // Arbitrary value.
    localparam logic [31:0] PRE = 32'h0000_071e;
    logic          core_clk = 1'b0;
    logic          rst      = 1'b1;
    logic          busy     = 1'b0;
    logic [NP-1:0] c_out    = '0;
    logic [NP-1:0] c_oe     = '0;
    logic [NP-1:0] p_in     = '0;
    logic          tck, tms, tdi, tdo, tdo_oe, scan;
    logic [NP-1:0] p_out, p_oe;
    wire logic     tdo_wire;
    int            num_errors   = 0;
    int            total_checks = 0;
    always #50 core_clk = ~core_clk;
    assign tdo_wire = tdo_oe ? tdo : 1'bz;
    bstap_top #(.NPINS(NP), .IDCODE(ID), .USERID(UID)) bstap_top_inst (
        .CORE_CLK_I(core_clk), .RST_I(rst), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
        .TDO_O(tdo), .TDO_OE_O(tdo_oe), .CONFIG_BUSY_I(busy), .CORE_OUT_I(c_out),
        .CORE_OE_I(c_oe), .PIN_IN_I(p_in), .PIN_OUT_O(p_out), .PIN_OE_O(p_oe),
        .SCAN_MODE_O(scan));
    bstap_tester bstap_tester_inst (.core_clk_i(core_clk), .tck_o(tck), .tms_o(tms),
        .tdi_o(tdi), .tdo_i(tdo_wire));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t %s: got %h exp %h", $time, msg, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // From idle through capture, n bits LSB first, update, back to idle.
    task automatic shift(input logic ir, input int n, input logic [31:0] din,
                         output logic [31:0] dout);
        logic b;
        dout = 32'h0;
        bstap_tester_inst.step(1'b1, 1'b1, b);
        if (ir) begin
            bstap_tester_inst.step(1'b1, 1'b1, b);
        end
        repeat (2) bstap_tester_inst.step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            bstap_tester_inst.step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        bstap_tester_inst.step(1'b1, 1'b1, b);
        bstap_tester_inst.step(1'b0, 1'b1, b);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_id();
        logic [31:0] d;
        check(tdo_oe, 1'b0, "tdo idle");
        bstap_tester_inst.tms_reset();
        shift(1'b0, 32, 32'h0, d);
        check(d, ID, "id after reset");
        check(tdo_oe, 1'b0, "tdo after shift");
    endtask
    task automatic t_bypass();
        logic [31:0] d;
        logic [9:0]  codes [2];
        codes = '{OP_BYPASS, 10'h155};
        foreach (codes[k]) begin
            shift(1'b1, 10, {22'h0, codes[k]}, d);
            check(d, {22'h0, IR_CAPTURE}, "ir capture");
            shift(1'b0, 9, 32'h0000_00b5, d);
            check(d, 32'h0000_016a, "bypass path");
        end
    endtask
    task automatic t_scan();
        logic [31:0] d;
        logic [31:0] exp;
        logic [NP-1:0] po;
        logic [NP-1:0] pe;
        c_out = 4'ha;
        c_oe = 4'h6;
        p_in = 4'h3;
        exp = 32'h0;
        for (int i = 0; i < NP; i++) begin
            exp[3*i +: 3] = {c_out[i], c_oe[i], p_in[i]};
            po[i] = PRE[3*i+2];
            pe[i] = PRE[3*i+1];
        end
        shift(1'b1, 10, {22'h0, OP_SAMPLE}, d);
        shift(1'b0, 3 * NP, PRE, d);
        check(d, exp, "sample capture");
        shift(1'b1, 10, {22'h0, OP_EXTEST}, d);
        check(scan, 1'b1, "scan mode");
        check({p_out, p_oe}, {po, pe}, "pins from chain");
        busy = 1'b1;
        for (int i = 0; i < 10 && p_oe !== '0; i++) @(negedge core_clk);
        check(p_oe, '0, "pins float");
        busy = 1'b0;
        bstap_tester_inst.tms_reset();
        check(scan, 1'b0, "scan off");
        check({p_out, p_oe}, {c_out, c_oe}, "pins normal");
        shift(1'b0, 32, 32'h0, d);
        check(d, ID, "id reloaded");
    endtask
    task automatic t_codes();
        logic [31:0] d;
        shift(1'b1, 10, {22'h0, OP_USERCODE}, d);
        shift(1'b0, 32, 32'h0, d);
        check(d, UID, "user code");
        shift(1'b1, 10, {22'h0, OP_CLAMP}, d);
        check(scan, 1'b1, "clamp scan mode");
        check({p_out, p_oe}, {4'h5, 4'hb}, "clamp pins");
        shift(1'b1, 10, {22'h0, OP_HIGHZ}, d);
        check({scan, p_oe}, {1'b1, 4'h0}, "highz pins");
        shift(1'b0, 9, 32'h0000_00b5, d);
        check(d, 32'h0000_016a, "highz bypass");
        bstap_tester_inst.tms_reset();
        check({scan, p_oe}, {1'b0, c_oe}, "pins after highz");
    endtask
    initial begin
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        t_reset_id();
        t_bypass();
        t_scan();
        t_codes();
        end_sim();
    end
    // The tests need about 2,400 core cycles; several times that means a hang.
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        end_sim();
    end
endmodule : bstap_top_tb
bind bstap_top bstap_top_assertions #(.NPINS(NPINS)) bstap_top_assertions_inst (
    .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .TCK_I(TCK_I), .TMS_I(TMS_I), .TDI_I(TDI_I),
    .TDO_O(TDO_O), .TDO_OE_O(TDO_OE_O), .CONFIG_BUSY_I(CONFIG_BUSY_I),
    .CORE_OUT_I(CORE_OUT_I), .CORE_OE_I(CORE_OE_I), .PIN_IN_I(PIN_IN_I),
    .PIN_OUT_O(PIN_OUT_O), .PIN_OE_O(PIN_OE_O), .SCAN_MODE_O(SCAN_MODE_O));
`default_nettype wire
